// File: hw/lpc_regs.sv
// led control and phy general control registers behind a wishbone slave
// Behaviour
// - led_control bits 15:11 ignore writes and read zero.
// - blink rate 00/01/10/11 gives 50/100/200/500 ms phases; resets to 10.
// - polarity bits 8,7,6 set speed, link, activity led active high when 1.
// - polarities load from straps on the first edge after reset; software writes override them.
// - drive bits 5,4,3 put forced bits 2,1,0 on the leds, else normal.
// - forced bits hold on/off level, used only while drive bit set.
// - auto crossover enable resets from strap, default 1, enables detection.
// - forced crossover bit swaps transmit and receive pairs.
// - pause receive flag resolved from pause bits, only for full duplex.
// - pause transmit flag resolved the same way, only for full duplex.
// - link flag reads 1 only for negotiated 100 Mb/s full-duplex link.
// - stretching bypass shows raw status on leds, no pulse stretch.
// - mode 1: link led shows good link, activity led pulses on activity.
//
// Register access over Wishbone was decided locally.
`timescale 1ns/100ps
module lpc_regs #(
    parameter int unsigned BLINK_20HZ_CYCLES = lpc_pkg::BLINK_20HZ_CYC,
    parameter int unsigned BLINK_10HZ_CYCLES = lpc_pkg::BLINK_10HZ_CYC,
    parameter int unsigned BLINK_5HZ_CYCLES  = lpc_pkg::BLINK_5HZ_CYC,
    parameter int unsigned BLINK_2HZ_CYCLES  = lpc_pkg::BLINK_2HZ_CYC,
    parameter int unsigned STRETCH_CYCLES    = lpc_pkg::STRETCH_CYC
) (
    input  wire logic                      clk_sys,
    input  wire logic                      nrst,
    input  wire logic                      wb_cyc_i,
    input  wire logic                      wb_stb_i,
    input  wire logic                      wb_we_i,
    input  wire logic [7:0]                wb_adr_i,
    input  wire logic [3:0]                wb_sel_i,
    input  wire logic [31:0]               wb_dat_i,
    output logic      [31:0]               wb_dat_o,
    output logic                           wb_ack_o,
    input  wire lpc_pkg::lpc_status_type   status,
    input  wire lpc_pkg::lpc_strap_type    strap,
    input  wire lpc_pkg::lpc_pause_adv_type pause_adv,
    output logic                           speed_indicator_pin,
    output logic                           link_indicator_pin,
    output logic                           activity_indicator_pin,
    output logic                           auto_xover_en,
    output logic                           pair_swap,
    output logic                           mac_pause_rx,
    output logic                           mac_pause_tx
);

    // led_control storage
    logic [1:0]  rate_q;
    logic [2:0]  pol_q;        // speed, link, activity
    logic [2:0]  drive_q;      // speed, link, activity
    logic [2:0]  force_q;      // speed, link, activity

    // phy_general_control storage
    logic        auto_xover_q;
    logic        force_xover_q;
    logic        bypass_q;
    logic [1:0]  indicator_mode_select_q;
    logic [4:0]  strapped_device_address_q;

    // status flags, registered from the core
    logic        pause_rx_q;
    logic        pause_tx_q;
    logic        an_link_q;

    // bus state
    logic        ack_q;
    logic [31:0] rdat_q;
    logic        strap_done_q;

    // blink timebase
    logic [lpc_pkg::CNT_W-1:0] blink_cnt_q;
    logic [lpc_pkg::CNT_W-1:0] blink_lim_w;
    logic        blink_phase_q;
    logic        act_seen_q;

    // decode
    logic        req_w;
    logic        wr_w;
    logic        hit_led_w;
    logic        hit_phy_w;
    logic [15:0] led_rd_w;
    logic [15:0] phy_rd_w;

    // lane inputs
    logic        speed_ind_w;
    logic        link_ind_w;
    logic        act_ind_w;
    logic        pause_rx_d;
    logic        pause_tx_d;
    logic        hcd_fd_w;

    // a request is answered once; the cycle after ack is a quiet one
    assign req_w     = wb_cyc_i & wb_stb_i & ~ack_q;
    assign wr_w      = req_w & wb_we_i;
    assign hit_led_w = (wb_adr_i[1:0] == 2'h0) && (wb_adr_i[7:2] == lpc_pkg::LED_CONTROL_IDX);
    assign hit_phy_w = (wb_adr_i[1:0] == 2'h0)
                       && (wb_adr_i[7:2] == lpc_pkg::PHY_GENERAL_CTRL_IDX);

    // ack follows one cycle after the strobe and drops the next cycle
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            ack_q <= 1'b0;
        else
            ack_q <= req_w;
    end

    // straps are caught on the first edge after reset release, never under reset
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            strap_done_q <= 1'b0;
        else
            strap_done_q <= 1'b1;
    end

    // blink rate field; upper bits 15:11 have no storage at all
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            rate_q <= lpc_pkg::RATE_RST;
        else if (wr_w && hit_led_w && wb_sel_i[1])
            rate_q <= wb_dat_i[lpc_pkg::LEDC_RATE_LSB +: 2];
    end

    // polarity: strap first, then software has the last word
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            pol_q <= lpc_pkg::POL_RST;
        else if (wr_w && hit_led_w)
        begin
            if (wb_sel_i[1])
                pol_q[2] <= wb_dat_i[lpc_pkg::LEDC_POL_LSB + 2];
            if (wb_sel_i[0])
                pol_q[1:0] <= wb_dat_i[lpc_pkg::LEDC_POL_LSB +: 2];
        end
        else if (!strap_done_q)
            pol_q <= {strap.speed_pol, strap.link_pol, strap.act_pol};
    end

    // manual drive and forced levels
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            drive_q <= 3'h0;
            force_q <= 3'h0;
        end
        else if (wr_w && hit_led_w && wb_sel_i[0])
        begin
            drive_q <= wb_dat_i[lpc_pkg::LEDC_DRIVE_LSB +: 3];
            force_q <= wb_dat_i[lpc_pkg::LEDC_FORCE_LSB +: 3];
        end
    end

    // crossover controls; auto enable takes its strap once after reset
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            auto_xover_q  <= lpc_pkg::AUTO_XOVER_RST;
            force_xover_q <= 1'b0;
        end
        else if (wr_w && hit_phy_w && wb_sel_i[1])
        begin
            auto_xover_q  <= wb_dat_i[lpc_pkg::PHYC_AUTO_XOVER];
            force_xover_q <= wb_dat_i[lpc_pkg::PHYC_FORCE_XOVR];
        end
        else if (!strap_done_q)
            auto_xover_q <= strap.auto_xover;
    end

    // stretch bypass and led mode; mode bit 0 has a strap
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            bypass_q                <= 1'b0;
            indicator_mode_select_q <= lpc_pkg::CFG_RST;
        end
        else if (wr_w && hit_phy_w && wb_sel_i[0])
        begin
            bypass_q                <= wb_dat_i[lpc_pkg::PHYC_BYPASS];
            indicator_mode_select_q <= wb_dat_i[lpc_pkg::PHYC_CFG_LSB +: 2];
        end
        else if (!strap_done_q)
            indicator_mode_select_q[0] <= strap.cfg0;
    end

    // device address is read only, taken from straps and never written
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            strapped_device_address_q <= lpc_pkg::ADDR_RST;
        else if (!strap_done_q)
            strapped_device_address_q <= strap.addr;
    end

    // pause resolution on bit 10 (symmetric) and bit 11 (asymmetric)
    assign hcd_fd_w = status.an_complete & status.full_duplex;
    always_comb
    begin
        pause_rx_d = 1'b0;
        pause_tx_d = 1'b0;
        if (pause_adv.local_advertisement[0] && pause_adv.partner_advertisement[0])
        begin
            pause_rx_d = 1'b1;
            pause_tx_d = 1'b1;
        end
        else if (pause_adv.local_advertisement == 2'b11
                 && pause_adv.partner_advertisement == 2'b10)
            pause_rx_d = 1'b1;
        else if (pause_adv.local_advertisement == 2'b10
                 && pause_adv.partner_advertisement == 2'b11)
            pause_tx_d = 1'b1;
    end

    // flags are gated by a full-duplex negotiated result
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            pause_rx_q <= 1'b0;
            pause_tx_q <= 1'b0;
            an_link_q  <= 1'b0;
        end
        else
        begin
            pause_rx_q <= pause_rx_d & hcd_fd_w;
            pause_tx_q <= pause_tx_d & hcd_fd_w;
            an_link_q  <= status.link_good & status.speed_100 & hcd_fd_w;
        end
    end

    // phase length chosen by the rate field
    always_comb
    begin
        case (lpc_pkg::lpc_rate_type'(rate_q))
            lpc_pkg::LPC_RATE_20HZ: blink_lim_w = lpc_pkg::CNT_W'(BLINK_20HZ_CYCLES - 1);
            lpc_pkg::LPC_RATE_10HZ: blink_lim_w = lpc_pkg::CNT_W'(BLINK_10HZ_CYCLES - 1);
            lpc_pkg::LPC_RATE_5HZ:  blink_lim_w = lpc_pkg::CNT_W'(BLINK_5HZ_CYCLES - 1);
            lpc_pkg::LPC_RATE_2HZ:  blink_lim_w = lpc_pkg::CNT_W'(BLINK_2HZ_CYCLES - 1);
            default:                blink_lim_w = lpc_pkg::CNT_W'(BLINK_5HZ_CYCLES - 1);
        endcase
    end

    // free running blink; >= lets a rate change to a shorter phase wrap at once
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            blink_cnt_q   <= '0;
            blink_phase_q <= 1'b0;
        end
        else if (blink_cnt_q >= blink_lim_w)
        begin
            blink_cnt_q   <= '0;
            blink_phase_q <= ~blink_phase_q;
        end
        else
            blink_cnt_q <= blink_cnt_q + 1'b1;
    end

    // activity seen in the current blink cycle; cleared at the end of an off phase
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            act_seen_q <= 1'b0;
        else if (status.activity)
            act_seen_q <= 1'b1;
        else if (blink_cnt_q >= blink_lim_w && !blink_phase_q)
            act_seen_q <= 1'b0;
    end

    // led meanings per mode; speed shows the rate in every mode
    always_comb
    begin
        speed_ind_w = status.speed_100;
        link_ind_w  = status.link_good;
        act_ind_w   = status.activity;
        if (indicator_mode_select_q == 2'b10)
        begin
            link_ind_w = status.link_good & (~act_seen_q | blink_phase_q);
            act_ind_w  = status.full_duplex;
        end
        else if (!indicator_mode_select_q[0])
            act_ind_w = status.collision;
    end

    // lanes: stretching skips the blinking link led so its off phase stays visible
    lpc_led_lane #(.STRETCH_CYCLES(STRETCH_CYCLES)) u_speed_lane (
        .clk_sys     (clk_sys),
        .nrst        (nrst),
        .ind         (speed_ind_w),
        .stretch_en  (~bypass_q),
        .active_high (pol_q[2]),
        .force_en    (drive_q[2]),
        .force_val   (force_q[2]),
        .pin         (speed_indicator_pin)
    );

    lpc_led_lane #(.STRETCH_CYCLES(STRETCH_CYCLES)) u_link_lane (
        .clk_sys     (clk_sys),
        .nrst        (nrst),
        .ind         (link_ind_w),
        .stretch_en  (~bypass_q & (indicator_mode_select_q[0] | ~indicator_mode_select_q[1])),
        .active_high (pol_q[1]),
        .force_en    (drive_q[1]),
        .force_val   (force_q[1]),
        .pin         (link_indicator_pin)
    );

    lpc_led_lane #(.STRETCH_CYCLES(STRETCH_CYCLES)) u_act_lane (
        .clk_sys     (clk_sys),
        .nrst        (nrst),
        .ind         (act_ind_w),
        .stretch_en  (~bypass_q),
        .active_high (pol_q[0]),
        .force_en    (drive_q[0]),
        .force_val   (force_q[0]),
        .pin         (activity_indicator_pin)
    );

    // read images; reserved fields are constant zero
    assign led_rd_w = {5'h00, rate_q, pol_q, drive_q, force_q};
    assign phy_rd_w = {auto_xover_q, force_xover_q, pause_rx_q, pause_tx_q, an_link_q,
                       3'h0, bypass_q, indicator_mode_select_q, strapped_device_address_q};

    // read data registered with the ack; unmapped addresses read zero
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            rdat_q <= 32'h0000_0000;
        else if (req_w)
        begin
            if (hit_led_w)
                rdat_q <= {16'h0000, led_rd_w};
            else if (hit_phy_w)
                rdat_q <= {16'h0000, phy_rd_w};
            else
                rdat_q <= 32'h0000_0000;
        end
    end

    // control outputs, each registered one cycle behind its register
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            auto_xover_en <= lpc_pkg::AUTO_XOVER_RST;
            pair_swap     <= 1'b0;
            mac_pause_rx  <= 1'b0;
            mac_pause_tx  <= 1'b0;
        end
        else
        begin
            auto_xover_en <= auto_xover_q;
            pair_swap     <= force_xover_q;
            mac_pause_rx  <= pause_rx_q;
            mac_pause_tx  <= pause_tx_q;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

endmodule

// File: hw/lpc_pkg.sv
// package: register map, field layout, reset values and timing for the led/phy control bank
package lpc_pkg;

    // word index of each register; byte address on the bus is four times the index
    localparam logic [5:0] LED_CONTROL_IDX      = 6'h18;
    localparam logic [5:0] PHY_GENERAL_CTRL_IDX = 6'h19;

    // led_control field positions
    localparam int LEDC_RATE_LSB   = 9;
    localparam int LEDC_POL_LSB    = 6;
    localparam int LEDC_DRIVE_LSB  = 3;
    localparam int LEDC_FORCE_LSB  = 0;

    // phy_general_control field positions
    localparam int PHYC_AUTO_XOVER = 15;
    localparam int PHYC_FORCE_XOVR = 14;
    localparam int PHYC_PAUSE_RX   = 13;
    localparam int PHYC_PAUSE_TX   = 12;
    localparam int PHYC_AN_LINK    = 11;
    localparam int PHYC_BYPASS     = 7;
    localparam int PHYC_CFG_LSB    = 5;
    localparam int PHYC_ADDR_LSB   = 0;

    // reset values, before the straps are taken in
    localparam logic [1:0] RATE_RST       = 2'h2;
    localparam logic [2:0] POL_RST        = 3'h0;
    localparam logic       AUTO_XOVER_RST = 1'h1;
    localparam logic [1:0] CFG_RST        = 2'h0;
    localparam logic [4:0] ADDR_RST       = 5'h01;

    // blink rate codes
    typedef enum logic [1:0] {
        LPC_RATE_20HZ = 2'b00,
        LPC_RATE_10HZ = 2'b01,
        LPC_RATE_5HZ  = 2'b10,
        LPC_RATE_2HZ  = 2'b11
    } lpc_rate_type;

    // timing: on/off durations in ms, clock in kHz, counts derived
    localparam int unsigned CLK_KHZ       = 10_000;
    localparam int unsigned BLINK_20HZ_MS = 50;
    localparam int unsigned BLINK_10HZ_MS = 100;
    localparam int unsigned BLINK_5HZ_MS  = 200;
    localparam int unsigned BLINK_2HZ_MS  = 500;
    localparam int unsigned STRETCH_MS    = 50;
    localparam int unsigned BLINK_20HZ_CYC = BLINK_20HZ_MS * CLK_KHZ;
    localparam int unsigned BLINK_10HZ_CYC = BLINK_10HZ_MS * CLK_KHZ;
    localparam int unsigned BLINK_5HZ_CYC  = BLINK_5HZ_MS * CLK_KHZ;
    localparam int unsigned BLINK_2HZ_CYC  = BLINK_2HZ_MS * CLK_KHZ;
    localparam int unsigned STRETCH_CYC    = STRETCH_MS * CLK_KHZ;
    localparam int          CNT_W          = 23;

    // live status from the transceiver core
    typedef struct packed {
        logic link_good;
        logic speed_100;
        logic full_duplex;
        logic an_complete;
        logic activity;
        logic collision;
    } lpc_status_type;

    // strap levels, valid while nrst is low and just after
    typedef struct packed {
        logic       speed_pol;
        logic       link_pol;
        logic       act_pol;
        logic       auto_xover;
        logic       cfg0;
        logic [4:0] addr;
    } lpc_strap_type;

    // pause advertisement bits 11:10 of local and partner words
    typedef struct packed {
        logic [1:0] local_advertisement;
        logic [1:0] partner_advertisement;
    } lpc_pause_adv_type;

endpackage

// File: hw/lpc_led_lane.sv
// one led output lane: pulse stretch, forced override, polarity and output flop
`timescale 1ns/100ps
module lpc_led_lane #(
    parameter int unsigned STRETCH_CYCLES = lpc_pkg::STRETCH_CYC
) (
    input  wire logic clk_sys,
    input  wire logic nrst,
    input  wire logic ind,
    input  wire logic stretch_en,
    input  wire logic active_high,
    input  wire logic force_en,
    input  wire logic force_val,
    output logic      pin
);

    logic [lpc_pkg::CNT_W-1:0] hold_q;
    logic                      on_w;
    logic                      lvl_w;

    // hold time restarts on every pulse so short bursts stay visible
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            hold_q <= '0;
        else if (ind)
            hold_q <= lpc_pkg::CNT_W'(STRETCH_CYCLES - 1);
        else if (hold_q != '0)
            hold_q <= hold_q - 1'b1;
    end

    // bypass shows the raw indication
    assign on_w  = ind | (stretch_en & (hold_q != '0));
    assign lvl_w = force_en ? force_val : on_w;

    // polarity applied last so forced values obey it too
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            pin <= 1'b1;                                  // off for active low
        else
            pin <= active_high ? lvl_w : ~lvl_w;
    end

endmodule

// File: testbench/lpc_regs_checker.sv
// checker for the control bank outputs
`timescale 1ns/100ps
module lpc_regs_checker (
    input wire logic                       clk_sys,
    input wire logic                       nrst,
    input wire logic                       wb_cyc_i,
    input wire logic                       wb_stb_i,
    input wire logic                       wb_we_i,
    input wire logic [7:0]                 wb_adr_i,
    input wire logic [3:0]                 wb_sel_i,
    input wire logic [31:0]                wb_dat_i,
    input wire logic [31:0]                wb_dat_o,
    input wire logic                       wb_ack_o,
    input wire lpc_pkg::lpc_status_type    status,
    input wire lpc_pkg::lpc_pause_adv_type pause_adv,
    input wire logic                       speed_indicator_pin,
    input wire logic                       link_indicator_pin,
    input wire logic                       auto_xover_en,
    input wire logic                       pair_swap,
    input wire logic                       mac_pause_rx,
    input wire logic                       mac_pause_tx
);
    logic       take;
    logic       wr_led;
    logic       wr_phy;
    logic       spd_exp;
    logic       lnk_exp;
    logic       rx_exp;
    logic       tx_exp;
    logic       fd;
    logic [3:0] adv;
    logic [1:0] up_q;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // requests and expected outcomes
    assign take    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr_led  = take & wb_we_i & (wb_adr_i == 8'h60) & (wb_sel_i[1:0] == 2'h3);
    assign wr_phy  = take & wb_we_i & (wb_adr_i == 8'h64) & wb_sel_i[1];
    assign spd_exp = wb_dat_i[2] ~^ wb_dat_i[8];
    assign lnk_exp = wb_dat_i[1] ~^ wb_dat_i[7];
    assign adv     = pause_adv;
    assign fd      = status.an_complete & status.full_duplex;
    assign rx_exp  = fd & ((adv[2] & adv[0]) | (adv == 4'he));
    assign tx_exp  = fd & ((adv[2] & adv[0]) | (adv == 4'hb));
    // pause outputs lag their inputs by two edges
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            up_q <= 2'h0;
        else if (up_q != 2'h3)
            up_q <= up_q + 2'h1;
    end
    property p_ack_take; take |=> wb_ack_o; endproperty
    a_ack_take: assert property (p_ack_take) else $error("no ack after request");
    property p_ack_idle; !take |=> !wb_ack_o; endproperty
    a_ack_idle: assert property (p_ack_idle) else $error("ack without request");
    property p_led_rsvd; take & !wb_we_i & (wb_adr_i == 8'h60) |=> wb_dat_o[31:11] == 21'h0;
    endproperty
    a_led_rsvd: assert property (p_led_rsvd) else $error("led reserved bits set");
    property p_xover; wr_phy |-> ##2 auto_xover_en == $past(wb_dat_i[15], 2); endproperty
    a_xover: assert property (p_xover) else $error("crossover enable wrong");
    property p_swap; wr_phy |-> ##2 pair_swap == $past(wb_dat_i[14], 2); endproperty
    a_swap: assert property (p_swap) else $error("pair swap wrong");
    property p_spd_force; wr_led & wb_dat_i[5] |-> ##2 speed_indicator_pin == $past(spd_exp, 2);
    endproperty
    a_spd_force: assert property (p_spd_force) else $error("forced speed led wrong");
    property p_lnk_force; wr_led & wb_dat_i[4] |-> ##2 link_indicator_pin == $past(lnk_exp, 2);
    endproperty
    a_lnk_force: assert property (p_lnk_force) else $error("forced link led wrong");
    property p_pause_rx; up_q == 2'h3 |-> mac_pause_rx == $past(rx_exp, 2); endproperty
    a_pause_rx: assert property (p_pause_rx) else $error("pause receive wrong");
    property p_pause_tx; up_q == 2'h3 |-> mac_pause_tx == $past(tx_exp, 2); endproperty
    a_pause_tx: assert property (p_pause_tx) else $error("pause transmit wrong");
endmodule

bind lpc_regs lpc_regs_checker u_chk (
    .clk_sys(clk_sys), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .status(status), .pause_adv(pause_adv),
    .speed_indicator_pin(speed_indicator_pin), .link_indicator_pin(link_indicator_pin),
    .auto_xover_en(auto_xover_en), .pair_swap(pair_swap),
    .mac_pause_rx(mac_pause_rx), .mac_pause_tx(mac_pause_tx)
);

// File: testbench/lpc_regs_tb.sv
// testbench for the led and phy control bank
`timescale 1ns/100ps
module lpc_regs_tb;
    logic                       clk_sys;
    logic                       nrst;
    logic                       wb_cyc;
    logic                       wb_stb;
    logic                       wb_we;
    logic [7:0]                 wb_adr;
    logic [3:0]                 wb_sel;
    logic [31:0]                wb_wdat;
    logic [31:0]                wb_rdat;
    logic                       wb_ack;
    lpc_pkg::lpc_status_type    status;
    lpc_pkg::lpc_strap_type     strap;
    lpc_pkg::lpc_pause_adv_type pause_adv;
    logic [2:0]                 pins;   // speed, link, activity
    logic                       auto_xover_en;
    logic                       pair_swap;
    logic                       mac_pause_rx;
    logic                       mac_pause_tx;
    int                         mismatches = 0;
    int                         num_checks = 0;
    int                         cycles = 0;
    int                         blink_tbl [4] = '{5, 10, 20, 50};

    // short counts keep the run brief
    lpc_regs #(
        .BLINK_20HZ_CYCLES(5), .BLINK_10HZ_CYCLES(10), .BLINK_5HZ_CYCLES(20),
        .BLINK_2HZ_CYCLES(50), .STRETCH_CYCLES(4)
    ) dut (
        .clk_sys(clk_sys), .nrst(nrst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
        .wb_ack_o(wb_ack), .status(status), .strap(strap), .pause_adv(pause_adv),
        .speed_indicator_pin(pins[2]), .link_indicator_pin(pins[1]),
        .activity_indicator_pin(pins[0]), .auto_xover_en(auto_xover_en),
        .pair_swap(pair_swap), .mac_pause_rx(mac_pause_rx), .mac_pause_tx(mac_pause_tx)
    );

    initial
    begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // hang guard
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            $display("mismatch at %0t: timeout", $time);
            close_out();
        end
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t: word %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_pins(input logic [2:0] got, input logic [2:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t: pins %b expected %b", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // classic cycle; request stands until ack is sampled high
    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [15:0] d,
                           output logic [31:0] q);
        @(posedge clk_sys);
        wb_cyc  <= 1'b1;
        wb_stb  <= 1'b1;
        wb_we   <= we;
        wb_adr  <= adr;
        wb_sel  <= 4'h3;
        wb_wdat <= {16'h0, d};
        do
            @(posedge clk_sys);
        while (wb_ack !== 1'b1);
        q = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] adr, input logic [15:0] d);
        logic [31:0] q;
        wb_xfer(1'b1, adr, d, q);
    endtask

    task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
        logic [31:0] q;
        wb_xfer(1'b0, adr, 16'h0, q);
        chk_word(q, exp);
    endtask

    task automatic set_st(input logic [5:0] v);
        @(posedge clk_sys);
        status <= lpc_pkg::lpc_status_type'(v);
    endtask

    // cycles until the link led next changes level
    task automatic meas(output int n);
        logic v;
        v = pins[1];
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (pins[1] === v && n < 200);
    endtask

    initial
    begin
        int   n;
        logic rx;
        logic tx;
        logic lk;
        nrst = 1'b0;
        {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_wdat} = '0;
        status = '0;
        pause_adv = '0;
        strap = lpc_pkg::lpc_strap_type'(10'h2ab);
        tick(10);
        nrst <= 1'b1;
        tick(2);
        rd(8'h60, 32'h0000_0540);
        rd(8'h64, 32'h0000_002b);
        chk_pins(pins, 3'b010);
        chk_pins({2'b0, auto_xover_en}, 3'b000);
        $display("test reset done");
        wr(8'h60, 16'hffff);
        rd(8'h60, 32'h0000_07ff);
        chk_pins(pins, 3'b111);
        wr(8'h60, 16'h01f8);
        tick(2);
        chk_pins(pins, 3'b000);
        wr(8'h60, 16'h0038);
        tick(2);
        chk_pins(pins, 3'b111);
        wr(8'h61, 16'h0000);
        rd(8'h60, 32'h0000_0038);
        rd(8'h68, 32'h0000_0000);
        $display("test led override done");
        wr(8'h64, 16'hffff);
        rd(8'h64, 32'h0000_c0eb);
        chk_pins({1'b0, pair_swap, auto_xover_en}, 3'b011);
        wr(8'h64, 16'h0000);
        rd(8'h64, 32'h0000_000b);
        chk_pins({1'b0, pair_swap, auto_xover_en}, 3'b000);
        $display("test phy control done");
        // every advertisement pair, with and without negotiated full duplex
        for (int i = 0; i < 64; i++)
        begin
            lk = i[5] & i[4];
            rx = lk & ((i[2] & i[0]) | (i[3:0] == 4'he));
            tx = lk & ((i[2] & i[0]) | (i[3:0] == 4'hb));
            pause_adv <= lpc_pkg::lpc_pause_adv_type'(i[3:0]);
            set_st({2'b11, i[4], i[5], 2'b00});
            tick(3);
            rd(8'h64, {16'h0, 2'b00, rx, tx, lk, 11'h00b});
            chk_pins({1'b0, mac_pause_rx, mac_pause_tx}, {1'b0, rx, tx});
        end
        $display("test pause done");
        wr(8'h60, 16'h01c0);
        set_st(6'b110001);
        tick(3);
        chk_pins(pins, 3'b111);
        set_st(6'b000000);
        tick(10);
        chk_pins(pins, 3'b000);
        wr(8'h64, 16'h00a0);
        set_st(6'b000010);
        tick(3);
        chk_pins(pins, 3'b001);
        set_st(6'b000000);
        tick(2);
        chk_pins(pins, 3'b000);
        wr(8'h64, 16'h0020);
        set_st(6'b000010);
        tick(3);
        set_st(6'b000000);
        tick(2);
        chk_pins(pins, 3'b001);
        tick(10);
        chk_pins(pins, 3'b000);
        wr(8'h64, 16'h0040);
        set_st(6'b101010);
        tick(3);
        chk_pins({2'b0, pins[0]}, 3'b001);
        // first measurement only finds the next phase edge
        for (int r = 0; r < 4; r++)
        begin
            wr(8'h60, {5'h0, r[1:0], 9'h1c0});
            meas(n);
            meas(n);
            chk_word(n, blink_tbl[r]);
            meas(n);
            chk_word(n, blink_tbl[r]);
        end
        $display("test led modes done");
        close_out();
    end
endmodule
